// file: rtl/ipof_formatter.sv
// Contract
// - Output stream is 8 or 16 bits wide with reference signals.
// - Port clock comes from a selectable source, at most 33 MHz.
// - Discontinuous stream is marked by a data qualifier.
// - Cycles without valid data drive 00 on all data pins.
// - Two arbitration bits steer video versus sliced text sharing the port.
// - Each 32-bit word is sent as four bytes or two 16-bit words.
// - Start and end codes framing video lines and text blocks.
// - Packing, luma-only line count and skip bit sit in format register.
// - Line count sets luma-only lines expected before a luma/chroma line.
// - Skip bit low drops leading luma-only lines of a field.
// - Only whole 32-bit words leave the packer, no planar formats.
// - Byte order for 4:2:2, 4:1:1 and luma-only packing.
// - Samples clipped to 01..FE or 08..F7 by the limit bit.
// - Video FIFO holds 32 words of 32 bits.
// - Port and FIFO read side run on the port clock.
// - FIFO keeps almost empty, filled, almost full and overflow flags.
// - Filled sets at almost full, clears only at almost empty.
// - Almost full and almost empty levels chosen by two 2-bit fields.
// - Almost full and filled flags can be routed to either general purpose pin.
// - Mappable events: field, vref, href, qualifier, page, flags, text.
// - Text buffer has two sections of 14 words each.
// - Text inserted after a video line end (arbitration 01 also waits for an empty FIFO), or at once with arbitration 11.
// - Qualifier and reference outputs active high after reset, invertible.
module ipof_formatter
    import ipof_pkg::*;
(
    // System clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Port clock
    input  wire logic        port_clk,
    // Register access
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    output logic      [7:0]  reg_rdata,
    // Scaled video in
    input  wire logic        vid_valid,
    input  wire logic [7:0]  vid_y,
    input  wire logic [7:0]  vid_cb,
    input  wire logic [7:0]  vid_cr,
    input  wire logic        vid_line_start,
    input  wire logic        vid_line_end,
    input  wire logic        vid_field_start,
    input  wire logic        vid_field_id,
    input  wire logic        vid_vref,
    // Sliced text in
    input  wire logic        txt_valid,
    input  wire logic [31:0] txt_word,
    input  wire logic        txt_line_done,
    // Image port
    input  wire logic        external_gate_input,
    output logic      [7:0]  port_data_lo,
    output logic      [7:0]  high_byte_pins,
    output logic             data_qualifier_pin,
    output logic             gp_out_pin_0,
    output logic             gp_out_pin_1,
    output logic      [1:0]  clk_src_sel
);

`include "ipof_regs.svh"

    localparam int TXT_DEPTH = 2 * int'(`IPOF_TXT_WORDS);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Limit clip
    function automatic logic [7:0] clip(input logic [7:0] v, input logic lim);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = lim ? `IPOF_CLIP_LO1 : `IPOF_CLIP_LO0;
        hi = lim ? `IPOF_CLIP_HI1 : `IPOF_CLIP_HI0;
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [5:0] g2b(input logic [5:0] g);
        logic [5:0] b;
        b[5] = g[5];
        for (int i = 4; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        g2b = b;
    endfunction

    function automatic logic [5:0] b2g(input logic [5:0] b);
        b2g = b ^ (b >> 1);
    endfunction

    function automatic logic [5:0] af_lvl(input logic [1:0] c);
        case (c)
            2'h0:    af_lvl = `IPOF_AF_L0;
            2'h1:    af_lvl = `IPOF_AF_L1;
            2'h2:    af_lvl = `IPOF_AF_L2;
            default: af_lvl = `IPOF_AF_L3;
        endcase
    endfunction

    function automatic logic [5:0] ae_lvl(input logic [1:0] c);
        case (c)
            2'h0:    ae_lvl = `IPOF_AE_L0;
            2'h1:    ae_lvl = `IPOF_AE_L1;
            2'h2:    ae_lvl = `IPOF_AE_L2;
            default: ae_lvl = `IPOF_AE_L3;
        endcase
    endfunction

    function automatic logic [7:0] vcode(input logic eav, input logic msb, input logic f);
        case ({eav, msb, f})
            3'b000:  vcode = `IPOF_SAV_M0_F0;
            3'b001:  vcode = `IPOF_SAV_M0_F1;
            3'b010:  vcode = `IPOF_SAV_M1_F0;
            3'b011:  vcode = `IPOF_SAV_M1_F1;
            3'b100:  vcode = `IPOF_EAV_M0_F0;
            3'b101:  vcode = `IPOF_EAV_M0_F1;
            3'b110:  vcode = `IPOF_EAV_M1_F0;
            default: vcode = `IPOF_EAV_M1_F1;
        endcase
    endfunction

    // ----------------------------------------
    // System domain
    // ----------------------------------------
    ipof_sys_t   s;
    ipof_sys_t   next_s;
    ipof_link_t  l;
    ipof_link_t  next_l;

    // Video FIFO storage, read from the port side
    logic [34:0] fifo_mem [0:int'(`IPOF_FIFO_DEPTH)-1];
    logic [31:0] txt_mem  [0:TXT_DEPTH-1];
    logic        push_en;
    logic [34:0] push_data;
    logic        txt_we;
    logic [4:0]  txt_widx;
    logic [4:0]  txt_ridx;
    logic [5:0]  level;
    logic        full;

    assign txt_ridx = (s.rsec ? 5'(`IPOF_TXT_WORDS) : 5'h00) + 5'(s.rcnt);

    always_comb begin
        logic [7:0]  yb;
        logic [7:0]  cb8;
        logic        yc;
        logic        two;
        logic [31:0] wtmp;
        logic [2:0]  sum;
        logic [3:0]  tlen;
        yb        = clip(vid_y, s.map_b[`IPOF_B_LIMIT]);
        cb8       = clip(s.phase[0] ? vid_cr : vid_cb, s.map_b[`IPOF_B_LIMIT]);
        yc        = (s.line_cnt == s.fmt_a[`IPOF_F_FOI]);
        two       = 1'b0;
        wtmp      = 32'h0000_0000;
        sum       = 3'h0;
        tlen      = s.rsec ? s.tlen1 : s.tlen0;
        next_s    = s;
        push_en   = 1'b0;
        push_data = 35'h0_0000_0000;
        txt_we    = 1'b0;
        txt_widx  = (s.wsec ? 5'(`IPOF_TXT_WORDS) : 5'h00) + 5'(s.wcnt);
        level     = s.wptr - g2b(s.rg_s2);
        full      = (level == `IPOF_FIFO_DEPTH);

        case (reg_addr)
            `IPOF_A_MAP_A:     next_s.rdata = s.map_a;
            `IPOF_A_MAP_B:     next_s.rdata = s.map_b;
            `IPOF_A_FIFO_CTRL: next_s.rdata = s.fifo_ctrl;
            `IPOF_A_STATUS:    next_s.rdata = {s.ovl, s.af, s.filled, s.ae, s.trdy, 2'b00};
            `IPOF_A_FMT_A:     next_s.rdata = s.fmt_a;
            `IPOF_A_FMT_B:     next_s.rdata = s.fmt_b;
            default:           next_s.rdata = 8'h00;
        endcase
        if (reg_wr) begin
            case (reg_addr)
                `IPOF_A_MAP_A:     next_s.map_a = reg_wdata;
                `IPOF_A_MAP_B:     next_s.map_b = reg_wdata;
                `IPOF_A_FIFO_CTRL: next_s.fifo_ctrl = reg_wdata;
                `IPOF_A_STATUS:    next_s.ovl = s.ovl & ~reg_wdata[`IPOF_B_OVL_CLR];
                `IPOF_A_FMT_A:     next_s.fmt_a = reg_wdata;
                `IPOF_A_FMT_B:     next_s.fmt_b = reg_wdata;
                default:           next_s.ovl = s.ovl;
            endcase
        end

        if (vid_field_start) begin
            next_s.line_cnt = 2'h0;
            next_s.started  = 1'b0;
        end else if (vid_line_start) begin
            next_s.line_cnt = yc ? 2'h0 : s.line_cnt + 2'h1;
            next_s.yc_line  = yc;
            next_s.started  = s.started | yc;
            next_s.line_on  = yc | s.started | s.fmt_a[`IPOF_B_SKIP];
            next_s.acc      = 32'h0000_0000;
            next_s.acc_cnt  = 3'h0;
            next_s.phase    = 3'h0;
            if (yc | s.started | s.fmt_a[`IPOF_B_SKIP]) begin
                push_en   = 1'b1;
                push_data = {TAG_VSAV, vcode(1'b0, ~s.fmt_b[`IPOF_B_PAGE], vid_field_id),
                             `IPOF_CODE_LEAD};
            end
        end else if (vid_line_end && s.line_on) begin
            next_s.line_on  = 1'b0;
            next_s.eol_seen = 1'b1;
            push_en   = 1'b1;
            push_data = {TAG_VEAV, vcode(1'b1, ~s.fmt_b[`IPOF_B_PAGE], vid_field_id),
                         `IPOF_CODE_LEAD};
        end else if (vid_valid && s.line_on && s.fifo_ctrl[`IPOF_F_ARB] != 2'b11) begin
            // Chroma then luma, chroma dropped on luma-only slots
            two = s.yc_line && s.fmt_a[`IPOF_F_PACK] != 3'h2
                  && !(s.fmt_a[`IPOF_F_PACK] == 3'h1 && s.phase[2]);
            wtmp = s.acc | ((two ? 32'({yb, cb8}) : 32'(yb)) << {s.acc_cnt, 3'b000});
            sum  = s.acc_cnt + (two ? 3'h2 : 3'h1);
            next_s.phase = s.phase + 3'h1;
            if (sum[2]) begin
                push_en        = 1'b1;
                push_data      = {TAG_VID, wtmp};
                next_s.acc     = 32'h0000_0000;
                next_s.acc_cnt = 3'h0;
            end else begin
                next_s.acc     = wtmp;
                next_s.acc_cnt = sum;
            end
        end

        case (s.arb)
            ARB_VIDEO: begin
                // Text at once (11), after line end (10), or after line end with FIFO drained (01)
                if (s.trdy[s.rsec] && (s.fifo_ctrl[`IPOF_F_ARB] == 2'b11
                    || (s.eol_seen && s.fifo_ctrl[`IPOF_F_ARB] == 2'b10)
                    || (s.eol_seen && s.fifo_ctrl[`IPOF_F_ARB] == 2'b01 && level == 6'h00))) begin
                    next_s.arb = ARB_TSAV;
                end
            end
            ARB_TSAV: begin
                if (!push_en && !full) begin
                    push_en     = 1'b1;
                    push_data   = {TAG_TSAV, vid_field_id ? `IPOF_TSAV_F1 : `IPOF_TSAV_F0,
                                   `IPOF_CODE_LEAD};
                    next_s.rcnt = 4'h0;
                    next_s.arb  = (tlen == 4'h0) ? ARB_TEAV : ARB_TDATA;
                end
            end
            ARB_TDATA: begin
                if (!push_en && !full) begin
                    push_en     = 1'b1;
                    push_data   = {TAG_TXT, txt_mem[txt_ridx]};
                    next_s.rcnt = s.rcnt + 4'h1;
                    if (s.rcnt == tlen - 4'h1) begin
                        next_s.arb = ARB_TEAV;
                    end
                end
            end
            ARB_TEAV: begin
                if (!push_en && !full) begin
                    push_en   = 1'b1;
                    push_data = {TAG_TEAV, vid_field_id ? `IPOF_TEAV_F1 : `IPOF_TEAV_F0,
                                 `IPOF_CODE_LEAD};
                    next_s.trdy[s.rsec] = 1'b0;
                    next_s.rsec     = ~s.rsec;
                    next_s.eol_seen = 1'b0;
                    next_s.arb      = ARB_VIDEO;
                end
            end
            default: next_s.arb = ARB_VIDEO;
        endcase

        // Two text sections, one fills while the other drains
        if (txt_valid && !s.trdy[s.wsec] && s.wcnt < `IPOF_TXT_WORDS) begin
            txt_we      = 1'b1;
            next_s.wcnt = s.wcnt + 4'h1;
        end
        if (txt_line_done && !s.trdy[s.wsec]) begin
            next_s.trdy[s.wsec] = 1'b1;
            next_s.wsec = ~s.wsec;
            next_s.wcnt = 4'h0;
            if (s.wsec) begin
                next_s.tlen1 = s.wcnt;
            end else begin
                next_s.tlen0 = s.wcnt;
            end
        end

        // Overflow on push into full FIFO, set beats clear
        if (push_en) begin
            if (full) begin
                next_s.ovl = 1'b1;
            end else begin
                next_s.wptr  = s.wptr + 6'h01;
                next_s.wgray = b2g(s.wptr + 6'h01);
            end
        end

        next_s.ae = (level <= ae_lvl(s.fifo_ctrl[`IPOF_F_FEL]));
        next_s.af = (level >= af_lvl(s.fifo_ctrl[`IPOF_F_FFL]));
        if (level >= af_lvl(s.fifo_ctrl[`IPOF_F_FFL])) begin
            next_s.filled = 1'b1;
        end else if (level <= ae_lvl(s.fifo_ctrl[`IPOF_F_FEL])) begin
            next_s.filled = 1'b0;
        end
        next_s.rg_s1 = l.rgray;
        next_s.rg_s2 = s.rg_s1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Memories carry no reset; pointers guard every read
    always_ff @(posedge clock) begin
        if (push_en && !full && !sys_rst) begin
            fifo_mem[s.wptr[4:0]] <= push_data;
        end
        if (txt_we) begin
            txt_mem[txt_widx] <= txt_word;
        end
    end

    // ----------------------------------------
    // Port domain
    // ----------------------------------------
    // Read side and pins on the port clock
    always_comb begin
        ipof_cfg_t  c;
        logic       dq_raw;
        logic       last;
        logic [7:0] ev;
        c      = l.cf_s2;
        dq_raw = 1'b0;
        last   = 1'b0;
        ev     = 8'h00;
        next_l = l;
        // Idle cycles drive zero on both bytes
        next_l.dlo = `IPOF_IDLE;
        next_l.dhi = `IPOF_IDLE;
        if (!l.have && l.rgray != l.wg_s2) begin
            next_l.ent   = fifo_mem[l.rptr[4:0]];
            next_l.have  = 1'b1;
            next_l.bidx  = 2'h0;
            next_l.rptr  = l.rptr + 6'h01;
            next_l.rgray = b2g(l.rptr + 6'h01);
        end else if (l.have && (c.gate || (l.ent[33] && c.nocode))) begin
            // Line and text markers drive href and sliced flags
            if (l.bidx == 2'h0 && l.ent[33]) begin
                if (l.ent[34]) begin
                    next_l.sliced = ~l.ent[32];
                end else begin
                    next_l.href = ~l.ent[32];
                    next_l.sliced = l.sliced & l.ent[32];
                end
            end
            if (l.ent[33] && c.nocode) begin
                next_l.have = 1'b0;
            end else begin
                // Byte or halfword serialisation, low byte first
                // High byte pins used only in wide mode
                dq_raw     = 1'b1;
                next_l.dlo = l.ent[{l.bidx, 3'b000} +: 8];
                next_l.dhi = c.wide ? l.ent[{l.bidx + 2'h1, 3'b000} +: 8] : `IPOF_IDLE;
                last       = c.wide ? l.bidx[1] : (l.bidx == 2'h3);
                next_l.bidx = l.bidx + (c.wide ? 2'h2 : 2'h1);
                next_l.have = ~last;
            end
        end
        ev = {next_l.sliced, c.af, c.filled, c.page, dq_raw, next_l.href, c.vref, c.fid};
        next_l.dq  = dq_raw ^ c.inv[0];
        // Pin mapping of events and flags
        next_l.gp0 = ev[c.sel0] ^ c.inv[1];
        next_l.gp1 = ev[c.sel1] ^ c.inv[2];
        if (l.rst_s2) begin
            next_l = '0;
        end
        // Synchronisers keep running through reset
        next_l.rst_s1 = sys_rst;
        next_l.rst_s2 = l.rst_s1;
        next_l.wg_s1  = s.wgray;
        next_l.wg_s2  = l.wg_s1;
        next_l.cf_s1  = {external_gate_input, vid_field_id, vid_vref, s.af, s.filled,
                         s.fmt_b[`IPOF_B_PAGE], s.fmt_a[`IPOF_B_NOCODE], s.fmt_a[`IPOF_B_WIDE],
                         s.map_b[`IPOF_F_INV], s.map_a[`IPOF_F_SEL1], s.map_a[`IPOF_F_SEL0]};
        next_l.cf_s2  = l.cf_s1;
    end

    always_ff @(posedge port_clk) begin
        l <= next_l;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata          = s.rdata;
    // Clock source select, external mux limited to 33 MHz
    assign clk_src_sel        = s.fmt_b[`IPOF_F_CLKSRC];
    assign port_data_lo       = l.dlo;
    assign high_byte_pins     = l.dhi;
    assign data_qualifier_pin = l.dq;
    assign gp_out_pin_0       = l.gp0;
    assign gp_out_pin_1       = l.gp1;

endmodule

// file: rtl/ipof_regs.svh
`ifndef IPOF_REGS_SVH
`define IPOF_REGS_SVH

// ----------------------------------------
// Register offsets and reset value
// ----------------------------------------
`define IPOF_A_MAP_A      8'h84
`define IPOF_A_MAP_B      8'h85
`define IPOF_A_FIFO_CTRL  8'h86
`define IPOF_A_STATUS     8'h87
`define IPOF_A_FMT_A      8'h93
`define IPOF_A_FMT_B      8'hC3
`define IPOF_RST_REG      8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IPOF_F_SEL0       2:0
`define IPOF_F_SEL1       5:3
`define IPOF_F_INV        2:0
`define IPOF_B_LIMIT      5
`define IPOF_F_FEL        1:0
`define IPOF_F_FFL        3:2
`define IPOF_F_ARB        7:6
`define IPOF_F_PACK       2:0
`define IPOF_F_FOI        4:3
`define IPOF_B_SKIP       5
`define IPOF_B_NOCODE     6
`define IPOF_B_WIDE       7
`define IPOF_F_CLKSRC     1:0
`define IPOF_B_PAGE       7
`define IPOF_B_OVL_CLR    7

// ----------------------------------------
// Sizes, levels and codes
// ----------------------------------------
`define IPOF_FIFO_DEPTH   6'h20
`define IPOF_TXT_WORDS    4'hE
`define IPOF_AF_L0        6'h10
`define IPOF_AF_L1        6'h18
`define IPOF_AF_L2        6'h1C
`define IPOF_AF_L3        6'h20
`define IPOF_AE_L0        6'h10
`define IPOF_AE_L1        6'h08
`define IPOF_AE_L2        6'h04
`define IPOF_AE_L3        6'h00
`define IPOF_CLIP_LO0     8'h01
`define IPOF_CLIP_HI0     8'hFE
`define IPOF_CLIP_LO1     8'h08
`define IPOF_CLIP_HI1     8'hF7
`define IPOF_CODE_LEAD    24'h0000FF
`define IPOF_IDLE         8'h00
`define IPOF_SAV_M0_F0    8'h0E
`define IPOF_SAV_M0_F1    8'h49
`define IPOF_EAV_M0_F0    8'h13
`define IPOF_EAV_M0_F1    8'h54
`define IPOF_SAV_M1_F0    8'h80
`define IPOF_SAV_M1_F1    8'hC7
`define IPOF_EAV_M1_F0    8'h9D
`define IPOF_EAV_M1_F1    8'hDA
`define IPOF_TSAV_F0      8'hAB
`define IPOF_TSAV_F1      8'hEC
`define IPOF_TEAV_F0      8'hB6
`define IPOF_TEAV_F1      8'hF1

`endif

// file: rtl/ipof_pkg.sv
package ipof_pkg;

    typedef enum logic [2:0] {
        TAG_VID  = 3'b000,
        TAG_TXT  = 3'b001,
        TAG_VSAV = 3'b010,
        TAG_VEAV = 3'b011,
        TAG_TSAV = 3'b110,
        TAG_TEAV = 3'b111
    } ipof_tag_t;

    typedef enum logic [1:0] {
        ARB_VIDEO = 2'b00,
        ARB_TSAV  = 2'b01,
        ARB_TDATA = 2'b10,
        ARB_TEAV  = 2'b11
    } ipof_arb_t;

    typedef struct packed {
        logic       gate, fid, vref, af, filled, page, nocode, wide;
        logic [2:0] inv, sel1, sel0;
    } ipof_cfg_t;

    typedef struct packed {
        logic [7:0]  map_a, map_b, fifo_ctrl, fmt_a, fmt_b, rdata;
        logic [31:0] acc;
        logic [2:0]  acc_cnt, phase;
        logic [1:0]  line_cnt;
        logic        started, line_on, yc_line, eol_seen;
        logic [5:0]  wptr, wgray, rg_s1, rg_s2;
        logic        ovl, filled, ae, af;
        logic        wsec, rsec;
        logic [3:0]  wcnt, rcnt, tlen0, tlen1;
        logic [1:0]  trdy;
        ipof_arb_t   arb;
    } ipof_sys_t;

    typedef struct packed {
        logic        rst_s1, rst_s2;
        logic [5:0]  wg_s1, wg_s2, rptr, rgray;
        ipof_cfg_t   cf_s1, cf_s2;
        logic [34:0] ent;
        logic        have;
        logic [1:0]  bidx;
        logic        href, sliced;
        logic [7:0]  dlo, dhi;
        logic        dq, gp0, gp1;
    } ipof_link_t;

endpackage

// file: testbench/ipof_props.sv
module ipof_props (
    // Clocks and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       port_clk,
    // Register port, video strobes and clock source select
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic       vid_valid,
    input wire logic       vid_line_start,
    input wire logic       vid_line_end,
    input wire logic [1:0] clk_src_sel,
    // Image port
    input wire logic       external_gate_input,
    input wire logic [7:0] port_data_lo,
    input wire logic [7:0] high_byte_pins,
    input wire logic       data_qualifier_pin
);
    // ----
    // Port checks assume qualifier polarity left at reset
    // ----
    clk_src_a: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == 8'hC3 |-> ##2 clk_src_sel == $past(reg_wdata[1:0], 2))
        else $error("clock source select mismatch");
    fmt_rb_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == 8'h93) ##1 (!reg_wr && reg_addr == 8'h93)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("format register readback mismatch");
    status_low_a: assert property (@(posedge clock) disable iff (sys_rst)
        reg_addr == 8'h87 |=> reg_rdata[1:0] == 2'b00)
        else $error("status low bits not zero");
    ovl_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!reg_wr && reg_addr == 8'h87) ##1 (reg_addr == 8'h87 && reg_rdata[7])
        |=> reg_rdata[7])
        else $error("overflow flag lost");
    ovl_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == 8'h87 && reg_wdata[7] && !vid_valid && !vid_line_start
        && !vid_line_end) ##1 reg_addr == 8'h87
        |=> !reg_rdata[7])
        else $error("overflow flag not cleared");
    idle_zero_a: assert property (@(posedge port_clk) disable iff (sys_rst)
        !data_qualifier_pin |-> port_data_lo == 8'h00 && high_byte_pins == 8'h00)
        else $error("idle cycle data not zero");
    run_len_a: assert property (@(posedge port_clk) disable iff (sys_rst)
        data_qualifier_pin [*4] |=> !data_qualifier_pin)
        else $error("entry longer than one word");
    gate_hold_a: assert property (@(posedge port_clk) disable iff (sys_rst)
        !external_gate_input [*5] |-> !data_qualifier_pin)
        else $error("data sent while gate held low");
    cover property (@(posedge port_clk) data_qualifier_pin [*4]);
    cover property (@(posedge port_clk) data_qualifier_pin && high_byte_pins != 8'h00);
    cover property (@(posedge clock) reg_addr == 8'h87 ##1 reg_rdata[7]);
endmodule

bind ipof_formatter ipof_props chk (.*);

// file: testbench/ipof_rx_model.sv
module ipof_rx_model (
    // Image port
    input  wire logic       port_clk,
    input  wire logic [7:0] port_data_lo,
    input  wire logic [7:0] high_byte_pins,
    input  wire logic       data_qualifier_pin,
    output logic            external_gate_input,
    // Bench control
    input  wire logic       wide,
    input  wire logic       stall
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] q[$];
    initial external_gate_input = 1'b0;
    always @(posedge port_clk) begin
        if (data_qualifier_pin === 1'b1) begin
            q.push_back(port_data_lo);
            if (wide) begin
                q.push_back(high_byte_pins);
            end
        end
        external_gate_input <= !stall;
    end
endmodule

// file: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'b0, port_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0;
    logic        vid_valid = 1'b0, vid_line_start = 1'b0, vid_line_end = 1'b0;
    logic        vid_field_start = 1'b0, stall = 1'b0, wide = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rd_v;
    logic [7:0]  vid_y = 8'h00, vid_cb = 8'h00, vid_cr = 8'h00;
    logic [7:0]  reg_rdata, port_data_lo, high_byte_pins;
    logic        data_qualifier_pin, gp_out_pin_0, gp_out_pin_1, external_gate_input;
    logic [1:0]  clk_src_sel;
    logic [7:0]  exp_q[$];
    int          miscompares = 0, n_checks = 0;
    logic        txt_valid = 1'b0, txt_line_done = 1'b0;
    logic [31:0] txt_word = 32'h0;
    // Field references held quiet
    wire logic        vid_field_id = 1'b0, vid_vref = 1'b0;
    ipof_formatter dut (.*);
    ipof_rx_model rx (.*);
    always #5 clock = ~clock;
    initial #3.3 forever #7.5 port_clk = ~port_clk;
    // ----
    // Shared tasks
    // ----
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
        rd_v = reg_rdata;
    endtask
    task automatic vid(input logic [3:0] k, input logic [7:0] y, b, r);
        @(negedge clock);
        {vid_field_start, vid_line_start, vid_line_end, vid_valid} = k;
        vid_y = y;
        vid_cb = b;
        vid_cr = r;
        @(negedge clock);
        {vid_field_start, vid_line_start, vid_line_end, vid_valid} = 4'h0;
    endtask
    task automatic line(input int n);
        vid(4'h4, 8'h00, 8'h00, 8'h00);
        for (int i = 0; i < n; i++) begin
            vid(4'h1, 8'h20 + 8'(i), 8'h40 + 8'(i), 8'h60 + 8'(i));
        end
        vid(4'h2, 8'h00, 8'h00, 8'h00);
    endtask
    task automatic drain(input string nm);
        for (int i = 0; i < 4000 && rx.q.size() < exp_q.size(); i++) @(negedge clock);
        if (rx.q.size() < exp_q.size()) begin
            $display("[ERR] %s expected %0d bytes seen %0d", nm, exp_q.size(), rx.q.size());
            miscompares++;
            summarize();
        end else begin
            foreach (exp_q[j]) chk(nm, exp_q[j], rx.q[j]);
            rx.q.delete();
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        logic [7:0] a[4] = '{8'h84, 8'h86, 8'h93, 8'h10};
        foreach (a[i]) begin
            rd(a[i]);
            chk("reset value", 8'h00, rd_v);
            wr(a[i], 8'h5A);
            rd(a[i]);
            chk("readback", (a[i] == 8'h10) ? 8'h00 : 8'h5A, rd_v);
        end
        wr(8'h85, 8'h04);
        wr(8'hC3, 8'h02);
        repeat (6) @(negedge clock);
        chk("clock source", 8'h02, {6'h0, clk_src_sel});
        chk("event pins", 8'h02, {6'h0, gp_out_pin_1, gp_out_pin_0});
        $display("test regs done");
    endtask
    task automatic t_422();
        wr(8'h85, 8'h20);
        wr(8'h86, 8'h00);
        wr(8'h93, 8'h00);
        vid(4'h8, 8'h00, 8'h00, 8'h00);
        vid(4'h4, 8'h00, 8'h00, 8'h00);
        vid(4'h1, 8'hFF, 8'h00, 8'h55);
        vid(4'h1, 8'h10, 8'h55, 8'hF9);
        vid(4'h2, 8'h00, 8'h00, 8'h00);
        exp_q = '{8'hFF, 8'h00, 8'h00, 8'h80, 8'h08, 8'hF7, 8'hF7, 8'h10,
                  8'hFF, 8'h00, 8'h00, 8'h9D};
        drain("coded 422 clipped");
        $display("test 422 done");
    endtask
    task automatic t_411();
        wr(8'h93, 8'hC1);
        wide = 1'b1;
        stall = 1'b1;
        line(8);
        repeat (50) @(negedge clock);
        chk("stalled bytes", 8'h00, 8'(rx.q.size()));
        stall = 1'b0;
        exp_q = '{8'h40, 8'h20, 8'h61, 8'h21, 8'h42, 8'h22, 8'h63, 8'h23,
                  8'h24, 8'h25, 8'h26, 8'h27};
        drain("wide 411");
        $display("test 411 done");
    endtask
    task automatic t_txt();
        wr(8'h93, 8'h80);
        @(negedge clock);
        {txt_valid, txt_word} = 33'h1_4433_2211;
        @(negedge clock);
        {txt_valid, txt_line_done} = 2'b01;
        @(negedge clock);
        txt_line_done = 1'b0;
        wr(8'h86, 8'h80);
        exp_q = '{8'hFF, 8'h00, 8'h00, 8'hAB, 8'h11, 8'h22, 8'h33, 8'h44,
                  8'hFF, 8'h00, 8'h00, 8'hB6};
        drain("text block");
        wr(8'h86, 8'h00);
        $display("test text done");
    endtask
    task automatic t_ovl();
        wr(8'h93, 8'h40);
        wide = 1'b0;
        stall = 1'b1;
        line(80);
        rd(8'h87);
        chk("full flags", 8'hE0, rd_v & 8'hE0);
        wr(8'h87, 8'h80);
        rd(8'h87);
        chk("overflow cleared", 8'h00, rd_v & 8'h80);
        stall = 1'b0;
        for (int i = 0; i < 300 && rd_v[5:4] !== 2'b01; i++) rd(8'h87);
        chk("drained flags", 8'h10, rd_v & 8'h70);
        exp_q = '{8'h40, 8'h20, 8'h61, 8'h21};
        drain("first word after stall");
        $display("test overflow done");
    endtask
    initial begin
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        repeat (10) @(negedge clock);
        t_regs();
        t_422();
        t_411();
        t_txt();
        t_ovl();
        summarize();
    end
endmodule
